//--- pkg/rss_map.svh
`ifndef RSS_MAP_SVH
`define RSS_MAP_SVH
`define RSS_CLK_PERIOD_NS    10
`define RSS_PWRT_TIME_US     64
`define RSS_OST_TOSC         1024
`define RSS_FILT_TIME_NS     100
`define RSS_FILT_CYCLES      ((`RSS_FILT_TIME_NS + `RSS_CLK_PERIOD_NS - 1) / `RSS_CLK_PERIOD_NS)
`define RSS_PWRT_CYCLES      ((`RSS_PWRT_TIME_US * 1000 + `RSS_CLK_PERIOD_NS - 1) / `RSS_CLK_PERIOD_NS)
`define RSS_STACK_DEPTH      16
`define RSS_OSC_LP           3'h0
`define RSS_OSC_XT           3'h1
`define RSS_OSC_HS           3'h2
`endif

//--- pkg/rss_pkg.sv
`default_nettype none
package rss_pkg;
  typedef enum logic [2:0] {
    RSS_ST_RESET = 3'h0,
    RSS_ST_PWRT  = 3'h1,
    RSS_ST_OST   = 3'h3,
    RSS_ST_PIN   = 3'h2,
    RSS_ST_RUN   = 3'h6
  } rss_state_t;

  typedef struct packed {
    logic stack_overflow_flag;
    logic stack_underflow_flag;
    logic reset_instr_flag_n;
    logic timeout_flag_n;
    logic powerdown_flag_n;
  } rss_flags_t;

  typedef struct packed {
    logic       ext_reset_pin_enable_cfg;
    logic       low_voltage_prog_cfg;
    logic       stack_fault_reset_enable;
    logic       powerup_timer_enable_n;
    logic [2:0] osc_mode;
  } rss_cfg_t;
endpackage
`default_nettype wire

//--- src/rss_sequencer.sv
// Notes on behaviour
// - pin reset off only when enable and low-voltage-programming bits are both 0.
// - enabled pin held low keeps device in reset, nothing runs.
// - pin reset path filters out short low pulses.
// - no reset source ever drives the pin; it stays an input.
// - disabled pin is a plain input, pull-up under software control.
// - missing watchdog clear resets device and updates timeout/powerdown flags.
// - reset instruction resets device and clears its flag to 0.
// - with stack-fault enable, push past 16 or pop below 0 resets, sets flag.
// - leaving programming mode acts like a power-on reset with full start-up.
// - power-up timer optionally delays start after power-on/brown-out, active-low enable.
// - start waits for power-up timer, oscillator timer, and pin release.
// - timers run regardless of pin; run begins once the risen pin has passed the filter.
// - oscillator start-up lasts 1024 periods, only in three crystal modes.
`timescale 1ns/1ns
`default_nettype none
`include "rss_map.svh"
module rss_sequencer #(
  parameter int PWRT_CYCLES = `RSS_PWRT_CYCLES,
  parameter int OST_CYCLES  = `RSS_OST_TOSC,
  parameter int FILT_CYCLES = `RSS_FILT_CYCLES,
  parameter int STACK_DEPTH = `RSS_STACK_DEPTH
) (
  input  wire logic              i_ref_clk,
  input  wire logic              i_rst_n,
  input  wire logic              i_por,
  input  wire logic              i_brownout_reset,
  input  wire logic              i_prog_mode,
  input  wire rss_pkg::rss_cfg_t i_cfg,
  input  wire logic              i_ext_reset_pin,
  input  wire logic              i_osc_tick,
  input  wire logic              i_wdt_timeout,
  input  wire logic              i_sleep_wdt,
  input  wire logic              i_reset_instr,
  input  wire logic              i_stack_push,
  input  wire logic              i_stack_pop,
  input  wire logic              i_sw_pullup_en,
  input  wire logic              i_clear_flags,
  output logic                   o_core_reset,
  output logic                   o_pin_reset_en,
  output logic                   o_pin_gpio,
  output logic                   o_pin_pullup_en,
  output logic                   o_pin_out,
  output logic                   o_pin_oe_n,
  output rss_pkg::rss_flags_t    o_flags,
  output logic [4:0]             o_stack_level
);
  rss_pkg::rss_state_t state_reg;
  rss_pkg::rss_state_t state_next;
  logic        pin_en;
  logic        sync1_reg;
  logic        sync2_reg;
  logic        filt_low_reg;
  logic [15:0] filt_cnt_reg;
  logic [31:0] pwrt_cnt_reg;
  logic [15:0] ost_cnt_reg;
  logic        cold;
  logic        warm_reset;
  logic        ovf;
  logic        unf;
  logic        crystal;
  logic        pwrt_done;
  logic        ost_done;
  logic        pin_held;

  assign pin_en = i_cfg.ext_reset_pin_enable_cfg | i_cfg.low_voltage_prog_cfg;
  assign cold = i_por | i_brownout_reset | i_prog_mode;
  assign crystal = (i_cfg.osc_mode == `RSS_OSC_LP) | (i_cfg.osc_mode == `RSS_OSC_XT)
                 | (i_cfg.osc_mode == `RSS_OSC_HS);
  assign ovf = i_stack_push & ~i_stack_pop & (o_stack_level == 5'(STACK_DEPTH));
  assign unf = i_stack_pop & ~i_stack_push & (o_stack_level == 5'h00);
  assign warm_reset = i_wdt_timeout | i_reset_instr
                    | (i_cfg.stack_fault_reset_enable & (ovf | unf));
  assign pin_held = pin_en & filt_low_reg;
  assign pwrt_done = i_cfg.powerup_timer_enable_n | (pwrt_cnt_reg >= 32'(PWRT_CYCLES));
  assign ost_done = ~crystal | (ost_cnt_reg >= 16'(OST_CYCLES));

  // two-flop synchroniser, then the filter reads the second flop only
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      sync1_reg <= 1'b1;
      sync2_reg <= 1'b1;
    end
    else
    begin
      sync1_reg <= i_ext_reset_pin;
      sync2_reg <= sync1_reg;
    end
  end

  // level must persist FILT_CYCLES before the filtered state flips
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      filt_low_reg <= 1'b0;
      filt_cnt_reg <= 16'h0000;
    end
    else if (sync2_reg == ~filt_low_reg)
      filt_cnt_reg <= 16'h0000;
    else if (filt_cnt_reg >= 16'(FILT_CYCLES - 1))
    begin
      filt_low_reg <= ~filt_low_reg;
      filt_cnt_reg <= 16'h0000;
    end
    else
      filt_cnt_reg <= filt_cnt_reg + 16'h0001;
  end

  // timers ignore the pin so both may expire while it is held low
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      pwrt_cnt_reg <= 32'h0000_0000;
      ost_cnt_reg  <= 16'h0000;
    end
    else if (cold)
    begin
      pwrt_cnt_reg <= 32'h0000_0000;
      ost_cnt_reg  <= 16'h0000;
    end
    else
    begin
      if (state_reg == rss_pkg::RSS_ST_PWRT && !pwrt_done)
        pwrt_cnt_reg <= pwrt_cnt_reg + 32'h0000_0001;
      if (state_reg == rss_pkg::RSS_ST_OST && !ost_done && i_osc_tick)
        ost_cnt_reg <= ost_cnt_reg + 16'h0001;
    end
  end

  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      rss_pkg::RSS_ST_RESET: state_next = rss_pkg::RSS_ST_PWRT;
      rss_pkg::RSS_ST_PWRT:  if (pwrt_done) state_next = rss_pkg::RSS_ST_OST;
      rss_pkg::RSS_ST_OST:   if (ost_done) state_next = rss_pkg::RSS_ST_PIN;
      rss_pkg::RSS_ST_PIN:   if (!pin_held) state_next = rss_pkg::RSS_ST_RUN;
      rss_pkg::RSS_ST_RUN:   if (pin_held || warm_reset) state_next = rss_pkg::RSS_ST_PIN;
      default:               state_next = rss_pkg::RSS_ST_RESET;
    endcase
    if (cold)
      state_next = rss_pkg::RSS_ST_RESET;
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      state_reg <= rss_pkg::RSS_ST_RESET;
    else
      state_reg <= state_next;
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_core_reset <= 1'b1;
    else
      o_core_reset <= (state_next != rss_pkg::RSS_ST_RUN);
  end

  // stack depth tracker, cleared by any reset
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_stack_level <= 5'h00;
    else if (state_reg != rss_pkg::RSS_ST_RUN || warm_reset || cold)
      o_stack_level <= 5'h00;
    else if (i_stack_push && !i_stack_pop && !ovf)
      o_stack_level <= o_stack_level + 5'h01;
    else if (i_stack_pop && !i_stack_push && !unf)
      o_stack_level <= o_stack_level - 5'h01;
  end

  // cause flags; a new cause wins over a software clear in the same cycle
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_flags <= 5'h07;
    else if (cold)
      o_flags <= 5'h07;
    else
    begin
      if (i_cfg.stack_fault_reset_enable && ovf)
        o_flags.stack_overflow_flag <= 1'b1;
      else if (i_clear_flags)
        o_flags.stack_overflow_flag <= 1'b0;
      if (i_cfg.stack_fault_reset_enable && unf)
        o_flags.stack_underflow_flag <= 1'b1;
      else if (i_clear_flags)
        o_flags.stack_underflow_flag <= 1'b0;
      if (i_reset_instr)
        o_flags.reset_instr_flag_n <= 1'b0;
      else if (i_clear_flags)
        o_flags.reset_instr_flag_n <= 1'b1;
      if (i_wdt_timeout)
      begin
        o_flags.timeout_flag_n   <= 1'b0;
        o_flags.powerdown_flag_n <= ~i_sleep_wdt;
      end
      else if (i_clear_flags)
      begin
        o_flags.timeout_flag_n   <= 1'b1;
        o_flags.powerdown_flag_n <= 1'b1;
      end
    end
  end

  // pin is never driven: output enable stays high (off)
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_pin_out       <= 1'b0;
      o_pin_oe_n      <= 1'b1;
      o_pin_reset_en  <= 1'b0;
      o_pin_gpio      <= 1'b1;
      o_pin_pullup_en <= 1'b1;
    end
    else
    begin
      o_pin_out       <= 1'b0;
      o_pin_oe_n      <= 1'b1;
      o_pin_reset_en  <= pin_en;
      o_pin_gpio      <= sync2_reg;
      o_pin_pullup_en <= pin_en | i_sw_pullup_en;
    end
  end
endmodule
`default_nettype wire

//--- test/rss_pin_model.sv
`timescale 1ns/1ns
`default_nettype none
module rss_pin_model (
  input  wire logic i_ref_clk,
  input  wire logic i_low,
  output logic      o_pin
);
  // pulled up: a released pin reads high
  initial o_pin = 1'h1;
  always @(posedge i_ref_clk) o_pin <= !i_low;
endmodule
`default_nettype wire

//--- test/rss_sequencer_checker.sv
`timescale 1ns/1ns
`default_nettype none
module rss_checker (
  input wire logic                i_ref_clk,
  input wire logic                i_rst_n,
  input wire logic                i_por,
  input wire logic                i_brownout_reset,
  input wire logic                i_prog_mode,
  input wire rss_pkg::rss_cfg_t   i_cfg,
  input wire logic                i_wdt_timeout,
  input wire logic                i_reset_instr,
  input wire logic                i_stack_push,
  input wire logic                i_stack_pop,
  input wire logic                o_core_reset,
  input wire logic                o_pin_reset_en,
  input wire logic                o_pin_gpio,
  input wire logic                o_pin_out,
  input wire logic                o_pin_oe_n,
  input wire rss_pkg::rss_flags_t o_flags,
  input wire logic [4:0]          o_stack_level
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);
  logic quiet;
  logic pen_cfg;
  assign quiet = !(i_por | i_brownout_reset | i_prog_mode | i_wdt_timeout | i_reset_instr
                   | i_stack_push | i_stack_pop);
  assign pen_cfg = i_cfg.ext_reset_pin_enable_cfg | i_cfg.low_voltage_prog_cfg;
  property p_oe; o_pin_oe_n && !o_pin_out; endproperty
  a_oe: assert property (p_oe) else $error("pin driven");
  // output is one cycle behind the config, and holds its reset value at release
  property p_pen; i_rst_n && $stable(pen_cfg) |=> o_pin_reset_en == $past(pen_cfg);
  endproperty
  a_pen: assert property (p_pen) else $error("pin enable");
  // filter needs ten low samples, so demand twelve before expecting reset
  property p_pin; o_pin_reset_en && $fell(o_pin_gpio) ##0 (!o_pin_gpio)[*8]
    ##1 (!o_pin_gpio)[*4] |-> ##[0:6] o_core_reset; endproperty
  a_pin: assert property (p_pin) else $error("pin low no reset");
  property p_filt; (o_pin_reset_en && !o_core_reset && quiet && o_pin_gpio)
    ##1 (quiet && !o_pin_gpio)[*3] ##1 (quiet && o_pin_gpio)[*8] |-> !o_core_reset; endproperty
  a_filt: assert property (p_filt) else $error("glitch reset");
  property p_wdt; i_wdt_timeout && !o_core_reset
    |-> ##[1:3] (o_core_reset && !o_flags.timeout_flag_n); endproperty
  a_wdt: assert property (p_wdt) else $error("wdt reset");
  property p_ri; i_reset_instr && !o_core_reset
    |-> ##[1:3] (o_core_reset && !o_flags.reset_instr_flag_n); endproperty
  a_ri: assert property (p_ri) else $error("instr reset");
  property p_ovf; i_stack_push && !i_stack_pop && o_stack_level == 5'h10 && !o_core_reset
    && i_cfg.stack_fault_reset_enable |-> ##[1:3] (o_core_reset && o_flags.stack_overflow_flag);
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow reset");
  property p_prog; $fell(i_prog_mode) && !i_cfg.powerup_timer_enable_n |-> o_core_reset[*8];
  endproperty
  a_prog: assert property (p_prog) else $error("prog exit");
  c_wdt: cover property (i_wdt_timeout && !o_core_reset);
  c_pin: cover property (o_pin_reset_en && !o_pin_gpio && o_core_reset);
  c_ovf: cover property (o_flags.stack_overflow_flag);
endmodule
`default_nettype wire

//--- test/test_rss_sequencer.sv
`timescale 1ns/1ns
`default_nettype none
module test_rss_sequencer;
  logic                i_ref_clk = 1'h0;
  logic                i_rst_n = 1'h0;
  logic                prog = 1'h0;
  logic                pin_low = 1'h0;
  logic                tick = 1'h0;
  logic                sw = 1'h1;
  logic                pull = 1'h0;
  logic [6:0]          ev = 7'h00;
  rss_pkg::rss_cfg_t   cfg = '{1'h1, 1'h0, 1'h1, 1'h0, 3'h1};
  logic                pin, rst, pen, gpio, pup, pout, oe_n;
  rss_pkg::rss_flags_t flags;
  logic [4:0]          lvl;
  int                  fail_count = 0;
  int                  checks = 0;
  int                  cyc = 0;
  int                  n;
  always #5 i_ref_clk = ~i_ref_clk;
  always @(posedge i_ref_clk) tick <= ~tick;
  rss_pin_model pm (.i_ref_clk(i_ref_clk), .i_low(pin_low), .o_pin(pin));
  rss_sequencer #(.PWRT_CYCLES(8), .OST_CYCLES(4)) dut (
    .i_ref_clk, .i_rst_n, .i_por(ev[5]), .i_brownout_reset(ev[6]), .i_prog_mode(prog),
    .i_cfg(cfg), .i_ext_reset_pin(pin), .i_osc_tick(tick), .i_wdt_timeout(ev[4]),
    .i_sleep_wdt(sw), .i_reset_instr(ev[3]), .i_stack_push(ev[2]), .i_stack_pop(ev[1]),
    .i_sw_pullup_en(pull), .i_clear_flags(ev[0]), .o_core_reset(rst), .o_pin_reset_en(pen),
    .o_pin_gpio(gpio), .o_pin_pullup_en(pup), .o_pin_out(pout), .o_pin_oe_n(oe_n),
    .o_flags(flags), .o_stack_level(lvl));
  task automatic conclude;
    if (fail_count == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string nm);
    checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("MISMATCH %s exp %0h seen %0h", nm, exp, seen);
    end
  endtask
  task automatic step(input int k);
    repeat (k) @(posedge i_ref_clk);
    #1;
  endtask
  task automatic pulse(input logic [6:0] v);
    @(posedge i_ref_clk) ev <= v;
    @(posedge i_ref_clk) ev <= 7'h00;
    #1;
  endtask
  task automatic timed;
    n = 0;
    while (rst === 1'h1 && n < 300)
    begin
      step(1);
      n++;
    end
  endtask
  // warm resets must not rerun the start-up timers
  task automatic warm(input logic [6:0] v);
    pulse(v);
    for (int i = 0; i < 8 && rst !== 1'h1; i++)
      step(1);
    chk(rst, 1'h1, "warm_rst");
    timed();
    chk(n <= 20, 1'h1, "warm_len");
  endtask
  always @(posedge i_ref_clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      fail_count++;
      conclude();
    end
  end
  initial
  begin
    step(1);
    chk(flags, 8'h07, "flags_rst");
    chk({pout, oe_n}, 8'h01, "pin_drive");
    step(1);
    @(posedge i_ref_clk) i_rst_n <= 1'h1;
    step(1);
    timed();
    chk(n >= 14, 1'h1, "cold_wait");
    for (int i = 0; i < 8; i++)
    begin
      @(posedge i_ref_clk) cfg[6:5] <= 2'(i);
      pull <= i[2];
      step(3);
      chk(pen, i[0] | i[1], "pin_en");
      chk(pup, i[0] | i[1] | i[2], "pullup");
    end
    @(posedge i_ref_clk) cfg[6:5] <= 2'h0;
    pin_low <= 1'h1;
    step(20);
    chk({rst, gpio}, 8'h00, "gpio_in");
    @(posedge i_ref_clk) cfg[6:5] <= 2'h2;
    pin_low <= 1'h0;
    step(20);
    @(posedge i_ref_clk) pin_low <= 1'h1;
    step(2);
    @(posedge i_ref_clk) pin_low <= 1'h0;
    step(20);
    chk(rst, 1'h0, "glitch");
    @(posedge i_ref_clk) pin_low <= 1'h1;
    step(20);
    chk(rst, 1'h1, "pin_hold");
    pulse(7'h20);
    step(40);
    chk(rst, 1'h1, "pin_wait");
    @(posedge i_ref_clk) pin_low <= 1'h0;
    timed();
    chk(n <= 20, 1'h1, "pin_go");
    warm(7'h10);
    chk(flags, 8'h04, "wdt_flags");
    @(posedge i_ref_clk) sw <= 1'h0;
    warm(7'h10);
    chk(flags, 8'h05, "wdt_awake");
    pulse(7'h01);
    warm(7'h08);
    chk(flags, 8'h03, "ri_flags");
    pulse(7'h01);
    repeat (16) pulse(7'h04);
    chk(lvl, 8'h10, "level");
    warm(7'h04);
    chk(flags, 8'h17, "ovf_flags");
    pulse(7'h01);
    warm(7'h02);
    chk(flags, 8'h0F, "unf_flags");
    pulse(7'h01);
    @(posedge i_ref_clk) cfg.stack_fault_reset_enable <= 1'h0;
    pulse(7'h02);
    step(2);
    chk({rst, flags}, 8'h07, "unf_off");
    @(posedge i_ref_clk) cfg.powerup_timer_enable_n <= 1'h1;
    for (int m = 0; m < 4; m++)
    begin
      @(posedge i_ref_clk) cfg.osc_mode <= (m == 3) ? 3'h4 : 3'(m);
      pulse(7'h40);
      timed();
      chk(n >= 6, m < 3, "ost_wait");
    end
    @(posedge i_ref_clk) cfg <= '{1'h1, 1'h0, 1'h1, 1'h0, 3'h1};
    prog <= 1'h1;
    step(5);
    @(posedge i_ref_clk) prog <= 1'h0;
    step(1);
    timed();
    chk(n >= 14, 1'h1, "prog_exit");
    conclude();
  end
endmodule
bind rss_sequencer rss_checker u_chk (.i_ref_clk, .i_rst_n, .i_por, .i_brownout_reset,
  .i_prog_mode, .i_cfg, .i_wdt_timeout, .i_reset_instr, .i_stack_push, .i_stack_pop,
  .o_core_reset, .o_pin_reset_en, .o_pin_gpio, .o_pin_out, .o_pin_oe_n, .o_flags,
  .o_stack_level);
`default_nettype wire
